// ===== dsw_ack_logic.sv
// What this block does
// - Unlimited data bytes per transfer
// - Eight data bits plus one acknowledge slot
// - Addressed receiver acknowledges every byte it accepts
// - Acknowledge low through whole clock high
// - After not-acknowledge, release data line
// - Writes: address, command, data byte
// - Reads: address with read, then data
// - Write protect refuses data bytes only
// - Ignore own address while write busy
// - After mux command, refuse data bytes
// - Read returns register of stored command
`timescale 1ns/100ps
module dsw_ack_logic import dsw_pkg::*; #(
  parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEF,
  parameter logic [7:0] MUX_CMD_MASK = MUX_MASK_DEF,
  parameter logic [7:0] MUX_CMD_VAL = MUX_VAL_DEF,
  parameter int BUSY_CYCLES = BUSY_CYCLES_DEF
) (
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  input wire logic LINK_CLK_IN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  input wire logic WP_IN,
  input wire logic [7:0] RD_DATA_IN,
  output logic [7:0] CMD_OUT,
  output logic EV_VALID_OUT,
  input wire logic EV_READY_IN,
  output logic EV_IS_DATA_OUT,
  output logic [7:0] EV_BYTE_OUT,
  output logic BUSY_OUT
);
  localparam int BW = $clog2(BUSY_CYCLES + 1);
  localparam logic [BW-1:0] BUSY_LOAD = BW'(BUSY_CYCLES);

  // ------------------------------------------------------------
  // Link domain synchronisers
  // ------------------------------------------------------------
  logic lrst_meta_reg;
  logic lrst_reg;
  logic [5:0] lin_meta_reg;
  logic [5:0] lin_sync_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  logic busy_reg;
  logic ev_seen_reg;
  logic rd_tog_reg;
  logic [7:0] rd_hold_reg;

  always_ff @(posedge LINK_CLK_IN)
  begin
    lrst_meta_reg <= SRST_IN;
    lrst_reg <= lrst_meta_reg;
    lin_meta_reg <= {SCL_IN, SDA_IN, WP_IN, busy_reg, ev_seen_reg, rd_tog_reg};
    lin_sync_reg <= lin_meta_reg;
    scl_d_reg <= lin_sync_reg[5];
    sda_d_reg <= lin_sync_reg[4];
  end

  wire scl_s = lin_sync_reg[5];
  wire sda_s = lin_sync_reg[4];
  wire wp_s = lin_sync_reg[3];
  wire busy_s = lin_sync_reg[2];
  wire ev_ack_s = lin_sync_reg[1];
  wire rd_tog_s = lin_sync_reg[0];

  // ------------------------------------------------------------
  // Link decode
  // ------------------------------------------------------------
  dsw_state_t state_reg;
  dsw_state_t state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] sh_reg;
  logic [7:0] sh_next;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic oe_reg;
  logic oe_next;
  logic rw_reg;
  logic rw_next;
  logic mux_reg;
  logic mux_next;
  logic ev_tog_reg;
  logic ev_tog_next;
  logic [EV_W-1:0] ev_word_reg;
  logic [EV_W-1:0] ev_word_next;
  logic rd_ack_reg;
  logic [7:0] rd_word_reg;

  wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire no_cond = ~start_det & ~stop_det;
  wire byte_done = scl_fall & (cnt_reg == BIT_ACK);
  wire ack_high = scl_rise & (cnt_reg == BIT_ACK);
  wire ack_end = scl_fall & (cnt_reg == BIT_END);
  wire bit_edge = scl_fall & (cnt_reg != CNT_ZERO) & (cnt_reg < BIT_ACK);
  wire addr_ok = (sh_reg[7:1] == SLAVE_ADDR) & ~busy_s;
  wire hs_free = (ev_ack_s == ev_tog_reg);
  wire is_mux_cmd = ((sh_reg & MUX_CMD_MASK) == MUX_CMD_VAL);
  wire data_ok = ~wp_s & ~mux_reg & hs_free;
  wire in_addr = (state_reg == ST_ADDR);
  wire in_cmd = (state_reg == ST_CMD);
  wire in_wdata = (state_reg == ST_WDATA);
  wire in_read = (state_reg == ST_READ);
  wire give_ack = (in_addr & addr_ok) | (in_cmd & hs_free)
                | (in_wdata & data_ok);
  wire [2:0] tx_idx = 3'(BIT_MSB - cnt_reg);

  // ------------------------------------------------------------
  // Link next state
  // ------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    tx_next = tx_reg;
    oe_next = oe_reg;
    rw_next = rw_reg;
    mux_next = mux_reg;
    ev_tog_next = ev_tog_reg;
    ev_word_next = ev_word_reg;
    if (start_det)
    begin
      state_next = ST_ADDR;
      cnt_next = CNT_ZERO;
      oe_next = 1'b0;
      mux_next = 1'b0;
    end
    else if (stop_det)
    begin
      state_next = ST_IDLE;
      cnt_next = CNT_ZERO;
      oe_next = 1'b0;
    end
    else
    begin
      if (scl_rise && cnt_reg < BIT_END)
        cnt_next = cnt_reg + 1'b1;
      if (scl_rise && cnt_reg < BIT_ACK)
        sh_next = {sh_reg[6:0], sda_s};
      if (ack_high && in_read && sda_s)
        state_next = ST_IGNORE;
      if (byte_done)
      begin
        oe_next = in_read ? 1'b0 : give_ack;
        if (in_addr)
        begin
          rw_next = sh_reg[0];
          if (!addr_ok)
            state_next = ST_IGNORE;
        end
        if ((in_cmd && hs_free) || (in_wdata && data_ok))
        begin
          ev_tog_next = ~ev_tog_reg;
          ev_word_next = {in_wdata ? EV_DATA : EV_CMD, sh_reg};
        end
        if (in_cmd)
          mux_next = is_mux_cmd;
      end
      else if (ack_end)
      begin
        cnt_next = CNT_ZERO;
        oe_next = 1'b0;
        if ((in_addr && rw_reg) || in_read)
        begin
          state_next = ST_READ;
          tx_next = rd_word_reg;
          oe_next = ~rd_word_reg[7];
        end
        else if (in_addr)
          state_next = ST_CMD;
        else if (in_cmd)
          state_next = ST_WDATA;
      end
      else if (bit_edge && in_read)
        oe_next = ~tx_reg[tx_idx];
    end
  end

  always_ff @(posedge LINK_CLK_IN)
  begin
    if (lrst_reg)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= CNT_ZERO;
      sh_reg <= '0;
      tx_reg <= '0;
      oe_reg <= 1'b0;
      rw_reg <= 1'b0;
      mux_reg <= 1'b0;
      ev_tog_reg <= 1'b0;
      ev_word_reg <= '0;
      rd_ack_reg <= 1'b0;
      rd_word_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      tx_reg <= tx_next;
      oe_reg <= oe_next;
      rw_reg <= rw_next;
      mux_reg <= mux_next;
      ev_tog_reg <= ev_tog_next;
      ev_word_reg <= ev_word_next;
      if (rd_tog_s != rd_ack_reg)
      begin
        rd_word_reg <= rd_hold_reg;
        rd_ack_reg <= rd_tog_s;
      end
    end
  end

  assign SDA_OUT = SDA_LOW;
  assign SDA_OE_OUT = oe_reg;

  // ------------------------------------------------------------
  // System domain
  // ------------------------------------------------------------
  logic [1:0] cin_meta_reg;
  logic [1:0] cin_sync_reg;
  logic [7:0] cmd_reg;
  logic [BW-1:0] busy_cnt_reg;
  logic [BW-1:0] busy_cnt_next;
  logic fifo_in_ready;
  logic [EV_W-1:0] fifo_out_data;

  always_ff @(posedge CLK_IN)
  begin
    cin_meta_reg <= {ev_tog_reg, rd_ack_reg};
    cin_sync_reg <= cin_meta_reg;
  end

  wire ev_pending = (cin_sync_reg[1] != ev_seen_reg);
  wire ev_push = ev_pending & fifo_in_ready;
  wire push_data = ev_push & ev_word_reg[EV_KIND_BIT];
  wire push_cmd = ev_push & ~ev_word_reg[EV_KIND_BIT];
  wire rd_refresh = (cin_sync_reg[0] == rd_tog_reg);

  always_comb
  begin
    busy_cnt_next = busy_cnt_reg;
    if (push_data)
      busy_cnt_next = BUSY_LOAD;
    else if (busy_cnt_reg != '0)
      busy_cnt_next = busy_cnt_reg - 1'b1;
  end

  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      ev_seen_reg <= 1'b0;
      cmd_reg <= '0;
      busy_cnt_reg <= '0;
      busy_reg <= 1'b0;
      rd_tog_reg <= 1'b0;
      rd_hold_reg <= '0;
    end
    else
    begin
      if (ev_push)
        ev_seen_reg <= cin_sync_reg[1];
      if (push_cmd)
        cmd_reg <= ev_word_reg[7:0];
      busy_cnt_reg <= busy_cnt_next;
      busy_reg <= (busy_cnt_next != '0);
      if (rd_refresh)
      begin
        rd_hold_reg <= RD_DATA_IN;
        rd_tog_reg <= ~rd_tog_reg;
      end
    end
  end

  dsw_fifo2 #(
    .WIDTH(EV_W),
    .DEPTH(2)
  ) u_buf (
    .clk_in(CLK_IN),
    .srst_in(SRST_IN),
    .in_valid_in(ev_pending),
    .in_ready_out(fifo_in_ready),
    .in_data_in(ev_word_reg),
    .out_valid_out(EV_VALID_OUT),
    .out_ready_in(EV_READY_IN),
    .out_data_out(fifo_out_data)
  );

  assign EV_IS_DATA_OUT = fifo_out_data[EV_KIND_BIT];
  assign EV_BYTE_OUT = fifo_out_data[7:0];
  assign CMD_OUT = cmd_reg;
  assign BUSY_OUT = busy_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Off until the link reset copy has settled
  wire link_off = SRST_IN | lrst_reg;

  a_start_clear:
  assert property (@(posedge LINK_CLK_IN) disable iff (link_off)
    start_det |=> cnt_reg == CNT_ZERO && state_reg == ST_ADDR && !oe_reg)
  else $error("start did not clear counter");

  a_cnt_bound:
  assert property (@(posedge LINK_CLK_IN) disable iff (link_off)
    cnt_reg <= BIT_END)
  else $error("bit counter past acknowledge slot");

  a_addr_ack:
  assert property (@(posedge LINK_CLK_IN) disable iff (link_off)
    byte_done && no_cond && in_addr && addr_ok |=> oe_reg)
  else $error("own address not acknowledged");

  a_addr_busy:
  assert property (@(posedge LINK_CLK_IN) disable iff (link_off)
    byte_done && no_cond && in_addr && busy_s
    |=> !oe_reg && state_reg == ST_IGNORE)
  else $error("address acknowledged while busy");

  a_ack_hold:
  assert property (@(posedge LINK_CLK_IN) disable iff (link_off)
    oe_reg && scl_s && scl_d_reg && no_cond |=> oe_reg)
  else $error("data line released while clock high");

  a_wp_nack:
  assert property (@(posedge LINK_CLK_IN) disable iff (link_off)
    byte_done && no_cond && in_wdata && wp_s
    |=> !oe_reg && $stable(ev_tog_reg))
  else $error("data byte taken under write protect");

  a_mux_nack:
  assert property (@(posedge LINK_CLK_IN) disable iff (link_off)
    byte_done && no_cond && in_wdata && mux_reg |=> !oe_reg)
  else $error("data byte after mux command acknowledged");

  a_read_nack:
  assert property (@(posedge LINK_CLK_IN) disable iff (link_off)
    ack_high && no_cond && in_read && sda_s
    |=> state_reg == ST_IGNORE ##1 !oe_reg)
  else $error("line driven after master not-acknowledge");

  a_busy_set:
  assert property (@(posedge CLK_IN) disable iff (SRST_IN)
    push_data |=> busy_reg ##1 busy_reg)
  else $error("write did not start busy period");
endmodule : dsw_ack_logic

// ===== dsw_pkg.sv
package dsw_pkg;
  // ------------------------------------------------------------
  // Bus framing
  // ------------------------------------------------------------
  localparam logic [3:0] BIT_MSB = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic SDA_LOW = 1'b0;
  // ------------------------------------------------------------
  // Defaults
  // ------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR_DEF = 7'h48;
  localparam logic [7:0] MUX_MASK_DEF = 8'hf0;
  localparam logic [7:0] MUX_VAL_DEF = 8'hf0;
  localparam int BUSY_TIME_NS = 3600000;
  localparam int CLK_MHZ = 200;
  localparam int BUSY_CYCLES_DEF = (BUSY_TIME_NS * CLK_MHZ + 999) / 1000;
  // ------------------------------------------------------------
  // Event word: kind bit above the byte
  // ------------------------------------------------------------
  localparam int EV_W = 9;
  localparam int EV_KIND_BIT = 8;
  localparam logic EV_CMD = 1'b0;
  localparam logic EV_DATA = 1'b1;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_CMD = 3'h2,
    ST_WDATA = 3'h3,
    ST_READ = 3'h4,
    ST_IGNORE = 3'h5
  } dsw_state_t;
endpackage : dsw_pkg

// ===== dsw_fifo2.sv
`timescale 1ns/100ps
module dsw_fifo2 import dsw_pkg::*; #(
  parameter int WIDTH = EV_W,
  parameter int DEPTH = 2
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  wire do_wr = in_valid_in & in_ready_out;
  wire do_rd = out_valid_out & out_ready_in;
  wire [PW-1:0] wr_ptr_next = (wr_ptr_reg == PTR_LAST) ? '0
                            : wr_ptr_reg + 1'b1;
  wire [PW-1:0] rd_ptr_next = (rd_ptr_reg == PTR_LAST) ? '0
                            : rd_ptr_reg + 1'b1;

  assign in_ready_out = (count_reg != CNT_FULL);
  assign out_valid_out = (count_reg != '0);
  assign out_data_out = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk_in)
  begin
    if (do_wr)
    begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr_reg <= wr_ptr_next;
      if (do_rd)
        rd_ptr_reg <= rd_ptr_next;
      if (do_wr && !do_rd)
        count_reg <= count_reg + 1'b1;
      else if (do_rd && !do_wr)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule : dsw_fifo2

// ===== dsw_master_model.sv
`timescale 1ns/100ps
module dsw_master_model (
  input wire logic link_clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_out
);
  localparam int HALF = 12;
  initial
  begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge link_clk_in);
    #1;
  endtask : wt
  // One pulse; reads low only if low at both samples taken during high
  task automatic pulse(input logic low, output logic seen);
    wt(4);
    sda_oe_out = low;
    wt(HALF);
    scl_out = 1'b1;
    wt(2);
    seen = sda_in;
    wt(HALF - 2);
    seen = seen | sda_in;
    scl_out = 1'b0;
  endtask : pulse
  task automatic start_cond;
    if (!scl_out)
    begin
      wt(4);
      sda_oe_out = 1'b0;
      wt(HALF);
      scl_out = 1'b1;
    end
    wt(HALF);
    sda_oe_out = 1'b1;
    wt(HALF);
    scl_out = 1'b0;
  endtask : start_cond
  task automatic stop_cond;
    wt(4);
    sda_oe_out = 1'b1;
    wt(HALF);
    scl_out = 1'b1;
    wt(HALF);
    sda_oe_out = 1'b0;
    wt(HALF);
  endtask : stop_cond
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      pulse(~b[i], s);
    pulse(1'b0, s);
    ack = ~s;
  endtask : wr_byte
  task automatic rd_byte(input logic m_ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      pulse(1'b0, b[i]);
    pulse(m_ack, s);
  endtask : rd_byte
endmodule : dsw_master_model

// ===== dsw_ack_logic_tb_top.sv
`timescale 1ns/100ps
module dsw_ack_logic_tb_top import dsw_pkg::*;;
  localparam logic [7:0] ADDR_W = {SLAVE_ADDR_DEF, 1'b0};
  localparam logic [7:0] ADDR_R = {SLAVE_ADDR_DEF, 1'b1};
  localparam logic [7:0] RD_KEY = 8'h5a;
  logic clk, srst, link_clk, scl, m_oe, sda, wp, ev_rdy;
  logic sda_oe, sda_o, ev_valid, ev_is_data, busy;
  logic [7:0] cmd, ev_byte, rd_data;
  logic [8:0] evq[$];
  int n_fail, n_tests;
  // ------------------------------------------------------------
  // Wiring and clocks
  // ------------------------------------------------------------
  assign sda = ~m_oe & ~(sda_oe & ~sda_o);
  // Register file stand-in: read value follows stored command
  assign rd_data = cmd ^ RD_KEY;
  dsw_ack_logic #(.BUSY_CYCLES(8000)) u_dut (
    .CLK_IN(clk), .SRST_IN(srst), .LINK_CLK_IN(link_clk),
    .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_o),
    .SDA_OE_OUT(sda_oe), .WP_IN(wp), .RD_DATA_IN(rd_data),
    .CMD_OUT(cmd), .EV_VALID_OUT(ev_valid), .EV_READY_IN(ev_rdy),
    .EV_IS_DATA_OUT(ev_is_data), .EV_BYTE_OUT(ev_byte),
    .BUSY_OUT(busy));
  dsw_master_model u_mst (.link_clk_in(link_clk), .sda_in(sda),
    .scl_out(scl), .sda_oe_out(m_oe));
  always #2.5 clk = ~clk;
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end
  always @(posedge clk)
    if (ev_valid === 1'b1 && ev_rdy)
      evq.push_back({ev_is_data, ev_byte});
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen,
        exp);
    end
  endtask : check
  function automatic logic [8:0] pop;
    if (evq.size() == 0)
      return 'x;
    return evq.pop_front();
  endfunction : pop
  task automatic wb(input logic [7:0] b, input logic exp);
    logic a;
    u_mst.wr_byte(b, a);
    check({8'h0, a}, {8'h0, exp});
  endtask : wb
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic s_write;
    int k;
    u_mst.start_cond;
    wb(ADDR_W, 1'b1);
    wb(8'h05, 1'b1);
    wb(8'ha5, 1'b1);
    wb(8'h3c, 1'b1);
    wb(8'hc3, 1'b1);
    u_mst.stop_cond;
    check({1'b0, cmd}, 9'h005);
    check(pop(), {EV_CMD, 8'h05});
    check(pop(), {EV_DATA, 8'ha5});
    check(pop(), {EV_DATA, 8'h3c});
    check(pop(), {EV_DATA, 8'hc3});
    check({8'h0, busy}, 9'h001);
    u_mst.start_cond;
    wb(ADDR_W, 1'b0);
    u_mst.stop_cond;
    k = 0;
    while (busy !== 1'b0 && k < 9000)
    begin
      @(posedge clk);
      k++;
    end
    check({8'h0, busy}, 9'h000);
    u_mst.start_cond;
    wb(ADDR_W, 1'b1);
    u_mst.stop_cond;
    check(9'(evq.size()), 9'h0);
  endtask : s_write
  task automatic s_wp;
    wp = 1'b1;
    u_mst.start_cond;
    wb(ADDR_W, 1'b1);
    wb(8'h06, 1'b1);
    wb(8'h77, 1'b0);
    u_mst.stop_cond;
    wp = 1'b0;
    check(pop(), {EV_CMD, 8'h06});
    check({8'h0, busy}, 9'h000);
    check(9'(evq.size()), 9'h0);
  endtask : s_wp
  task automatic s_mux;
    u_mst.start_cond;
    wb(ADDR_W, 1'b1);
    wb(8'hf3, 1'b1);
    wb(8'h12, 1'b0);
    wb(8'h34, 1'b0);
    u_mst.stop_cond;
    check(pop(), {EV_CMD, 8'hf3});
    check({8'h0, busy}, 9'h000);
    check(9'(evq.size()), 9'h0);
  endtask : s_mux
  task automatic s_read;
    logic [7:0] b;
    logic a;
    u_mst.start_cond;
    wb(ADDR_W, 1'b1);
    wb(8'h21, 1'b1);
    u_mst.start_cond;
    wb(ADDR_R, 1'b1);
    u_mst.rd_byte(1'b1, b);
    check({1'b0, b}, {1'b0, 8'h21 ^ RD_KEY});
    u_mst.rd_byte(1'b0, b);
    check({1'b0, b}, {1'b0, 8'h21 ^ RD_KEY});
    u_mst.pulse(1'b0, a);
    check({8'h0, a}, 9'h001);
    u_mst.stop_cond;
    u_mst.start_cond;
    wb(ADDR_R, 1'b1);
    u_mst.rd_byte(1'b0, b);
    check({1'b0, b}, {1'b0, 8'h21 ^ RD_KEY});
    u_mst.stop_cond;
    check(pop(), {EV_CMD, 8'h21});
    u_mst.start_cond;
    wb({SLAVE_ADDR_DEF ^ 7'h01, 1'b0}, 1'b0);
    u_mst.stop_cond;
    check(9'(evq.size()), 9'h0);
  endtask : s_read
  task automatic s_stall;
    logic a;
    logic [7:0] b;
    logic [8:0] expq[$];
    @(posedge clk);
    #1;
    ev_rdy = 1'b0;
    u_mst.start_cond;
    wb(ADDR_W, 1'b1);
    for (int i = 0; i < 5; i++)
    begin
      b = 8'h01 + 8'(i * 17);
      u_mst.wr_byte(b, a);
      // Two buffered plus one in the crossing, then refused
      check({8'h0, a}, {8'h0, (i < 3)});
      if (i < 3)
        expq.push_back({i != 0, b});
    end
    u_mst.stop_cond;
    check({8'h0, a}, 9'h000);
    check({8'h0, ev_valid}, 9'h001);
    @(posedge clk);
    #1;
    ev_rdy = 1'b1;
    repeat (8) @(posedge clk);
    foreach (expq[i])
      check(pop(), expq[i]);
    check({8'h0, ev_valid}, 9'h000);
    check(9'(evq.size()), 9'h0);
  endtask : s_stall
  initial
  begin
    clk = 1'b0;
    srst = 1'b1;
    wp = 1'b0;
    ev_rdy = 1'b1;
    n_fail = 0;
    n_tests = 0;
    repeat (12) @(posedge clk);
    repeat (10) @(posedge link_clk);
    @(posedge clk);
    #1;
    srst = 1'b0;
    repeat (10) @(posedge link_clk);
    check({ev_valid, cmd}, 9'h000);
    check({8'h0, sda_oe}, 9'h000);
    check({8'h0, busy}, 9'h000);
    s_write;
    s_wp;
    s_mux;
    s_read;
    s_stall;
    complete_run;
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    n_fail++;
    complete_run;
  end
endmodule : dsw_ack_logic_tb_top
